// ==== hdl/hcs_strap_select.sv ====
`timescale 1ns/1ps
// Operation
// R1: Sample select-0 at reset release, then clock
// R2: Sample select-1, form two-bit method code
// R3: Code 01: SMBus slave at 0101100
// R4: Code 10: internal defaults plus strap pins
// R5: Code 11: EEPROM load; 00 reserved
// R6: Clock select: low crystal, high external
// R7: Reset low is asserted; at least 1 us
// R8: Local power detect high means self power
// R9: Test input left open or grounded
// R10: Default mode samples fixed-port strap, LED polarity
// R11: Latch port power polarity at release
// R12: Default mode: power detect sets sensing mode
// R13: Method code held until next reset
module hcs_strap_select
    import hcs_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic config_method_bit0_in,
    input wire logic config_method_bit1_in,
    input wire logic ext_clock_select_in,
    input wire logic local_power_detect_in,
    input wire logic [1:0] fixed_port_strap_in,
    input wire logic port_power_polarity_strap_in,
    input wire logic test_mode_in,
    input wire logic scl_drive_low_in,
    input wire logic port_power_request_in,
    input wire logic [1:0] green_on_in,
    input wire logic downloaded_self_powered_in,
    input wire logic downloaded_ganged_sense_in,
    output logic [1:0] config_method_out,
    output logic config_valid_out,
    output logic smbus_mode_out,
    output logic eeprom_mode_out,
    output logic default_mode_out,
    output logic reserved_mode_out,
    output logic [6:0] smbus_slave_addr_out,
    output logic scl_serial_clock_out,
    output logic scl_out,
    output logic scl_oe_out,
    output logic osc_external_clock_out,
    output logic osc_driver_enable_out,
    output logic local_power_available_out,
    output logic self_powered_out,
    output logic current_sense_ganged_out,
    output logic port1_fixed_out,
    output logic port2_fixed_out,
    output logic compound_device_out,
    output logic [1:0] green_active_low_out,
    output logic [1:0] green_indicator_out,
    output logic green_indicator_oe_out,
    output logic port_power_active_high_out,
    output logic port_power_enable_out,
    output logic port_power_enable_oe_out
);

    logic [HCS_SYNC_W-1:0] pins_raw;
    logic [HCS_SYNC_W-1:0] pins_sync;

    assign pins_raw[HCS_SY_SEL0] = config_method_bit0_in;
    assign pins_raw[HCS_SY_SEL1] = config_method_bit1_in;
    assign pins_raw[HCS_SY_EXTCLK] = ext_clock_select_in;
    assign pins_raw[HCS_SY_LPWR] = local_power_detect_in;
    assign pins_raw[HCS_SY_FIX0] = fixed_port_strap_in[0];
    assign pins_raw[HCS_SY_FIX1] = fixed_port_strap_in[1];
    assign pins_raw[HCS_SY_PPOL] = port_power_polarity_strap_in;
    assign pins_raw[HCS_SY_TEST] = test_mode_in;
    assign pins_raw[HCS_SY_SCL] = config_method_bit0_in;
    assign pins_raw[HCS_SY_SPARE] = 1'b0;

    hcs_sync u_sync (
        .sys_clk_in(sys_clk_in),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    // Captured configuration
    hcs_state_t state_reg, state_next;
    logic [1:0] method_reg, method_next;
    logic [1:0] fixed_reg, fixed_next;
    logic ppol_reg, ppol_next;

    // Live outputs
    logic [6:0] addr_reg, addr_next;
    logic sclk_reg, sclk_next;
    logic scl_oe_reg, scl_oe_next;
    logic extclk_reg, extclk_next;
    logic osc_drv_reg, osc_drv_next;
    logic lpwr_reg, lpwr_next;
    logic selfp_reg, selfp_next;
    logic gang_reg, gang_next;
    logic [1:0] gr_pol_reg, gr_pol_next;
    logic [1:0] gr_reg, gr_next;
    logic gr_oe_reg, gr_oe_next;
    logic pp_reg, pp_next;
    logic pp_oe_reg, pp_oe_next;

    logic running;
    logic serial_mode;
    logic dflt_mode;

    assign running = (state_reg == HCS_ST_RUN);
    assign dflt_mode = running && (method_reg == HCS_CFG_DEFAULT);
    assign serial_mode = running
                         && ((method_reg == HCS_CFG_SMBUS) || (method_reg == HCS_CFG_EEPROM));

    // Capture sequencer: the first clock after release takes the straps
    always_comb begin
        state_next = state_reg;
        method_next = method_reg;
        fixed_next = fixed_reg;
        ppol_next = ppol_reg;
        case (state_reg)
            HCS_ST_SAMPLE: begin
                method_next = {pins_sync[HCS_SY_SEL1], pins_sync[HCS_SY_SEL0]}; // R1 R2
                fixed_next = {pins_sync[HCS_SY_FIX1], pins_sync[HCS_SY_FIX0]}; // R10
                ppol_next = pins_sync[HCS_SY_PPOL]; // R11
                state_next = HCS_ST_RUN;
            end
            HCS_ST_RUN: begin
                // Select pins are ignored from here until reset returns
                state_next = HCS_ST_RUN; // R13
            end
            default: begin
                state_next = HCS_ST_SAMPLE;
            end
        endcase
    end

    // Reset low at any time restarts sampling; pulse width is the system's duty
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin // R7
            state_reg <= HCS_ST_SAMPLE;
            method_reg <= HCS_CFG_RESERVED;
            fixed_reg <= 2'h0;
            ppol_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            method_reg <= method_next;
            fixed_reg <= fixed_next;
            ppol_reg <= ppol_next;
        end
    end

    // Output and pin behaviour derived from the captured code
    always_comb begin
        addr_next = HCS_ADDR_NONE;
        if (running && (method_reg == HCS_CFG_SMBUS)) begin
            addr_next = HCS_SMBUS_ADDR; // R3
        end

        // Once sampled, the select-0 pin serves only as the serial clock, and only in the SMBus and EEPROM modes
        sclk_next = serial_mode ? pins_sync[HCS_SY_SCL] : 1'b1; // R1
        scl_oe_next = serial_mode && scl_drive_low_in; // R3 R5

        extclk_next = pins_sync[HCS_SY_EXTCLK]; // R6
        osc_drv_next = ~pins_sync[HCS_SY_EXTCLK]; // R6
        lpwr_next = pins_sync[HCS_SY_LPWR]; // R8

        // Defaults follow the power detect pin; downloads carry their own
        if (dflt_mode) begin
            selfp_next = pins_sync[HCS_SY_LPWR]; // R4 R12
            gang_next = pins_sync[HCS_SY_LPWR]; // R12
        end else begin
            selfp_next = downloaded_self_powered_in;
            gang_next = downloaded_ganged_sense_in;
        end

        // Strap bit n sets LED n+1 active low; downloaded configs use active low
        if (dflt_mode) begin
            gr_pol_next = fixed_reg; // R10
        end else begin
            gr_pol_next = 2'h3;
        end
        // LED pins stay released until their strap levels are taken
        gr_next = green_on_in ^ gr_pol_reg;
        gr_oe_next = running;

        // Test input is deliberately not wired to any behaviour
        pp_next = running ? (port_power_request_in ~^ ppol_reg) : ~ppol_reg; // R11
        pp_oe_next = running;
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            addr_reg <= HCS_ADDR_NONE;
            sclk_reg <= 1'b1;
            scl_oe_reg <= 1'b0;
            extclk_reg <= 1'b0;
            osc_drv_reg <= 1'b1;
            lpwr_reg <= 1'b0;
            selfp_reg <= 1'b0;
            gang_reg <= 1'b0;
            gr_pol_reg <= 2'h3;
            gr_reg <= 2'h0;
            gr_oe_reg <= 1'b0;
            pp_reg <= 1'b0;
            pp_oe_reg <= 1'b0;
        end else begin
            addr_reg <= addr_next;
            sclk_reg <= sclk_next;
            scl_oe_reg <= scl_oe_next;
            extclk_reg <= extclk_next;
            osc_drv_reg <= osc_drv_next;
            lpwr_reg <= lpwr_next;
            selfp_reg <= selfp_next;
            gang_reg <= gang_next;
            gr_pol_reg <= gr_pol_next;
            gr_reg <= gr_next;
            gr_oe_reg <= gr_oe_next;
            pp_reg <= pp_next;
            pp_oe_reg <= pp_oe_next;
        end
    end

    // Mode flags are flops of their own so each flag output leaves a register
    logic smbus_reg, eeprom_reg, dflt_reg, resv_reg, valid_reg;
    logic smbus_next, eeprom_next, dflt_next, resv_next, valid_next;
    logic fix1_next, fix2_next, comp_next;
    logic fix1_reg, fix2_reg, comp_reg;

    always_comb begin
        valid_next = (state_next == HCS_ST_RUN);
        smbus_next = valid_next && (method_next == HCS_CFG_SMBUS); // R3
        eeprom_next = valid_next && (method_next == HCS_CFG_EEPROM); // R5
        dflt_next = valid_next && (method_next == HCS_CFG_DEFAULT); // R4
        resv_next = valid_next && (method_next == HCS_CFG_RESERVED); // R5
        // 01 fixes port 1; 10 and 11 fix both ports
        fix1_next = dflt_next && (fixed_next != 2'h0); // R10
        fix2_next = dflt_next && fixed_next[1]; // R10
        comp_next = fix1_next;
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            valid_reg <= 1'b0;
            smbus_reg <= 1'b0;
            eeprom_reg <= 1'b0;
            dflt_reg <= 1'b0;
            resv_reg <= 1'b0;
            fix1_reg <= 1'b0;
            fix2_reg <= 1'b0;
            comp_reg <= 1'b0;
        end else begin
            valid_reg <= valid_next;
            smbus_reg <= smbus_next;
            eeprom_reg <= eeprom_next;
            dflt_reg <= dflt_next;
            resv_reg <= resv_next;
            fix1_reg <= fix1_next;
            fix2_reg <= fix2_next;
            comp_reg <= comp_next;
        end
    end

    assign config_method_out = method_reg;
    assign config_valid_out = valid_reg;
    assign smbus_mode_out = smbus_reg;
    assign eeprom_mode_out = eeprom_reg;
    assign default_mode_out = dflt_reg;
    assign reserved_mode_out = resv_reg;
    assign smbus_slave_addr_out = addr_reg;
    assign scl_serial_clock_out = sclk_reg;
    assign scl_out = 1'b0;
    assign scl_oe_out = scl_oe_reg;
    assign osc_external_clock_out = extclk_reg;
    assign osc_driver_enable_out = osc_drv_reg;
    assign local_power_available_out = lpwr_reg;
    assign self_powered_out = selfp_reg;
    assign current_sense_ganged_out = gang_reg;
    assign port1_fixed_out = fix1_reg;
    assign port2_fixed_out = fix2_reg;
    assign compound_device_out = comp_reg;
    assign green_active_low_out = gr_pol_reg;
    assign green_indicator_out = gr_reg;
    assign green_indicator_oe_out = gr_oe_reg;
    assign port_power_active_high_out = ppol_reg;
    assign port_power_enable_out = pp_reg;
    assign port_power_enable_oe_out = pp_oe_reg;

endmodule

// ==== hdl/hcs_sync.sv ====
`timescale 1ns/1ps
module hcs_sync
    import hcs_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic [HCS_SYNC_W-1:0] async_in,
    output logic [HCS_SYNC_W-1:0] sync_out
);

    // No reset on purpose: the chain keeps tracking the pins while reset is
    // low, so at release it already holds the pin levels from two clocks before.
    genvar i;
    generate
        for (i = 0; i < HCS_SYNC_W; i++) begin : g_bit
            logic meta_reg;
            logic stable_reg;
            always_ff @(posedge sys_clk_in) begin
                meta_reg <= async_in[i];
                stable_reg <= meta_reg;
            end
            assign sync_out[i] = stable_reg;
        end
    endgenerate

endmodule

// ==== pkg/hcs_pkg.sv ====
package hcs_pkg;

    // Two-bit configuration method code, {bit1, bit0}
    localparam logic [1:0] HCS_CFG_RESERVED = 2'h0;
    localparam logic [1:0] HCS_CFG_SMBUS = 2'h1;
    localparam logic [1:0] HCS_CFG_DEFAULT = 2'h2;
    localparam logic [1:0] HCS_CFG_EEPROM = 2'h3;

    // Seven-bit slave address answered in the SMBus download method
    localparam logic [6:0] HCS_SMBUS_ADDR = 7'h2C;
    localparam logic [6:0] HCS_ADDR_NONE = 7'h00;

    // Positions of the pin levels inside the synchroniser vector
    localparam int HCS_SYNC_W = 10;
    localparam int HCS_SY_SEL0 = 0;
    localparam int HCS_SY_SEL1 = 1;
    localparam int HCS_SY_EXTCLK = 2;
    localparam int HCS_SY_LPWR = 3;
    localparam int HCS_SY_FIX0 = 4;
    localparam int HCS_SY_FIX1 = 5;
    localparam int HCS_SY_PPOL = 6;
    localparam int HCS_SY_TEST = 7;
    localparam int HCS_SY_SCL = 8;
    localparam int HCS_SY_SPARE = 9;

    // Shortest legal reset pulse and its length in system clocks
    localparam int HCS_CLK_PERIOD_NS = 4;
    localparam int HCS_RESET_MIN_NS = 1000;
    localparam int HCS_RESET_MIN_CYC = (HCS_RESET_MIN_NS + HCS_CLK_PERIOD_NS - 1)
                                       / HCS_CLK_PERIOD_NS;

    // Capture sequencer, one-hot
    typedef enum logic [1:0] {
        HCS_ST_SAMPLE = 2'h1,
        HCS_ST_RUN = 2'h2
    } hcs_state_t;

endpackage

// ==== sim/hcs_board_model.sv ====
`timescale 1ns/1ps
module hcs_board_model
    import hcs_pkg::*;
#(
    parameter int RST_CYC = HCS_RESET_MIN_CYC + 10
)
(
    input wire logic sys_clk_in,
    input wire logic boot_in,
    input wire logic [1:0] code_in,
    output logic reset_n_out,
    output logic sel0_out,
    output logic sel1_out,
    output logic test_out
);
    // Power-on reset is the bench's 8-cycle pulse; later pulses meet the minimum
    int cnt = 8;
    assign test_out = 1'b0;
    assign {sel1_out, sel0_out} = code_in;
    always_ff @(posedge sys_clk_in) begin
        if (boot_in) begin
            cnt <= RST_CYC;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    assign reset_n_out = (cnt == 0);
endmodule

// ==== sim/hcs_strap_select_bench.sv ====
`timescale 1ns/1ps
module hcs_strap_select_bench
    import hcs_pkg::*;
;
    logic sys_clk_in = 1'b0, boot = 1'b0;
    logic [1:0] code = 2'h2, fixed_port_strap_in = 2'h0, green_on_in = 2'h3;
    logic ext_clock_select_in = 1'b0, local_power_detect_in = 1'b0;
    logic port_power_polarity_strap_in = 1'b0, scl_drive_low_in = 1'b1;
    logic port_power_request_in = 1'b1, downloaded_self_powered_in = 1'b1;
    logic downloaded_ganged_sense_in = 1'b1;
    logic reset_n_in, config_method_bit0_in, config_method_bit1_in, test_mode_in;
    logic [1:0] config_method_out, green_active_low_out, green_indicator_out;
    logic [6:0] smbus_slave_addr_out;
    logic config_valid_out, smbus_mode_out, eeprom_mode_out, default_mode_out;
    logic reserved_mode_out, scl_serial_clock_out, scl_out, scl_oe_out;
    logic osc_external_clock_out, osc_driver_enable_out, local_power_available_out;
    logic self_powered_out, current_sense_ganged_out, port1_fixed_out, port2_fixed_out;
    logic compound_device_out, green_indicator_oe_out, port_power_active_high_out;
    logic port_power_enable_out, port_power_enable_oe_out;
    int err_count = 0, tests_run = 0;

    hcs_board_model u_hcs_board_model (.sys_clk_in(sys_clk_in), .boot_in(boot),
        .code_in(code), .reset_n_out(reset_n_in), .sel0_out(config_method_bit0_in),
        .sel1_out(config_method_bit1_in), .test_out(test_mode_in));
    hcs_strap_select u_hcs_strap_select (.*);

    initial begin
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    // Straps stay put through the whole reset so the synchroniser settles
    task automatic boot_with(input logic [1:0] c);
        int n;
        code <= c;
        boot <= 1'b1;
        @(posedge sys_clk_in);
        boot <= 1'b0;
        n = 0;
        repeat (2) @(posedge sys_clk_in);
        chk(config_valid_out, 1'b0);
        chk(port_power_enable_oe_out, 1'b0);
        while (config_valid_out !== 1'b1 && n < 400) begin
            @(posedge sys_clk_in);
            n++;
        end
        chk(n < 400, 1'b1);
        repeat (4) @(posedge sys_clk_in);
    endtask

    task automatic t_modes();
        for (int c = 0; c < 4; c++) begin
            boot_with(c[1:0]);
            chk(config_method_out, c[1:0]);
            chk(smbus_mode_out, c == 1);
            chk(smbus_slave_addr_out, (c == 1) ? HCS_SMBUS_ADDR : HCS_ADDR_NONE);
            chk(default_mode_out, c == 2);
            chk({eeprom_mode_out, reserved_mode_out}, {c == 3, c == 0});
            chk(self_powered_out, c != 2);
            chk(scl_oe_out, c == 1 || c == 3);
            chk(current_sense_ganged_out, c != 2);
            chk(scl_out, 1'b0);
            chk(green_indicator_oe_out, 1'b1);
            chk(port_power_enable_oe_out, 1'b1);
            // Pull the shared pin low: serial modes must now see it as a clock
            code <= {c[1], 1'b0};
            scl_drive_low_in <= 1'b0;
            port_power_request_in <= 1'b0;
            repeat (4) @(posedge sys_clk_in);
            chk(scl_serial_clock_out, !c[0]);
            chk(scl_oe_out, 1'b0);
            chk(port_power_enable_out, 1'b1);
            chk(config_method_out, c[1:0]);
            scl_drive_low_in <= 1'b1;
            port_power_request_in <= 1'b1;
        end
    endtask

    task automatic t_hold();
        boot_with(HCS_CFG_DEFAULT);
        code <= HCS_CFG_SMBUS;
        repeat (6) @(posedge sys_clk_in);
        chk(config_method_out, HCS_CFG_DEFAULT);
        chk(smbus_mode_out, 1'b0);
    endtask

    task automatic t_straps();
        for (int f = 0; f < 4; f++) begin
            fixed_port_strap_in <= f[1:0];
            port_power_polarity_strap_in <= f[0];
            local_power_detect_in <= f[1];
            ext_clock_select_in <= f[0];
            boot_with(HCS_CFG_DEFAULT);
            chk({port1_fixed_out, port2_fixed_out}, {f != 0, f[1]});
            chk(compound_device_out, f != 0);
            chk(green_active_low_out, f[1:0]);
            chk(green_indicator_out, 2'h3 ^ f[1:0]);
            chk(port_power_active_high_out, f[0]);
            chk(port_power_enable_out, f[0]);
            chk(local_power_available_out, f[1]);
            chk({self_powered_out, current_sense_ganged_out}, {f[1], f[1]});
            chk({osc_external_clock_out, osc_driver_enable_out}, {f[0], !f[0]});
            green_on_in <= 2'h1;
            repeat (2) @(posedge sys_clk_in);
            chk(green_indicator_out, 2'h1 ^ f[1:0]);
            green_on_in <= 2'h3;
        end
    endtask

    task automatic print_verdict();
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (10000) @(posedge sys_clk_in);
        err_count++;
        print_verdict();
    end

    initial begin
        // Let the power-on pulse end and its capture settle before any reboot
        repeat (10) @(posedge sys_clk_in);
        chk(config_method_out, HCS_CFG_DEFAULT);
        t_modes();
        t_hold();
        t_straps();
        print_verdict();
    end
endmodule

// ==== sim/hcs_strap_select_checker.sv ====
`timescale 1ns/1ps
module hcs_strap_select_checker
    import hcs_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic config_method_bit0_in,
    input wire logic config_method_bit1_in,
    input wire logic [1:0] config_method_out,
    input wire logic config_valid_out,
    input wire logic smbus_mode_out,
    input wire logic eeprom_mode_out,
    input wire logic default_mode_out,
    input wire logic reserved_mode_out,
    input wire logic [6:0] smbus_slave_addr_out,
    input wire logic osc_external_clock_out,
    input wire logic osc_driver_enable_out,
    input wire logic port_power_active_high_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    a_capture_prompt: assert property (!config_valid_out |=> config_valid_out)
        else $error("capture late");
    a_method_capture: assert property ($rose(config_valid_out) |-> config_method_out ==
        {$past(config_method_bit1_in, 3), $past(config_method_bit0_in, 3)})
        else $error("method wrong");
    a_method_held: assert property (config_valid_out && $past(config_valid_out)
        |-> $stable(config_method_out)) else $error("method moved");
    a_smbus_decode: assert property (config_valid_out
        |-> smbus_mode_out == (config_method_out == HCS_CFG_SMBUS)) else $error("smbus flag");
    a_default_decode: assert property (config_valid_out
        |-> default_mode_out == (config_method_out == HCS_CFG_DEFAULT)) else $error("dflt flag");
    a_eeprom_reserved: assert property (config_valid_out |->
        {eeprom_mode_out, reserved_mode_out} == {config_method_out == HCS_CFG_EEPROM,
        config_method_out == HCS_CFG_RESERVED}) else $error("eeprom flag");
    a_slave_addr: assert property (config_valid_out && $past(config_valid_out) |->
        smbus_slave_addr_out == (smbus_mode_out ? HCS_SMBUS_ADDR : HCS_ADDR_NONE))
        else $error("address");
    a_clock_pair: assert property (osc_driver_enable_out == !osc_external_clock_out)
        else $error("osc pair");
    a_polarity_hold: assert property (config_valid_out && $past(config_valid_out, 2)
        |-> $stable(port_power_active_high_out)) else $error("polarity moved");

    cover property (smbus_mode_out);
    cover property (default_mode_out);
    cover property (eeprom_mode_out);
endmodule

bind hcs_strap_select hcs_strap_select_checker u_hcs_strap_select_checker (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .config_method_bit0_in(config_method_bit0_in),
    .config_method_bit1_in(config_method_bit1_in),
    .config_method_out(config_method_out),
    .config_valid_out(config_valid_out),
    .smbus_mode_out(smbus_mode_out),
    .eeprom_mode_out(eeprom_mode_out),
    .default_mode_out(default_mode_out),
    .reserved_mode_out(reserved_mode_out),
    .smbus_slave_addr_out(smbus_slave_addr_out),
    .osc_external_clock_out(osc_external_clock_out),
    .osc_driver_enable_out(osc_driver_enable_out),
    .port_power_active_high_out(port_power_active_high_out)
);
